// File: hw/vec_addr_pkg.sv
/*
  Constants and carrier types for the interrupt vector address generator.
  Assumes a single processor clock and a synchronous active-high reset.
*/
package vec_addr_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W = 24;
  localparam int PTR_W = 16;
  localparam int SRC_W = 13;
  localparam int TRAP_W = 5;

  // ==========================================================================
  // Table offsets
  // ==========================================================================
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] OFS_EXT0 = 8'h01;
  localparam logic [7:0] OFS_SP0_TX = 8'h05;
  localparam logic [7:0] OFS_SP0_RX = 8'h06;
  localparam logic [7:0] OFS_SP1_TX = 8'h07;
  localparam logic [7:0] OFS_SP1_RX = 8'h08;
  localparam logic [7:0] OFS_TIM0 = 8'h09;
  localparam logic [7:0] OFS_TIM1 = 8'h0A;
  localparam logic [7:0] OFS_DMA0 = 8'h0B;
  localparam logic [7:0] OFS_DMA1 = 8'h0C;
  localparam logic [7:0] OFS_TRAP0 = 8'h20;
  localparam logic [4:0] TRAP_LAST = 5'h1B;
  localparam logic [ADDR_W-1:0] HIGH_BASE = 24'h809FC0;
  localparam int BASE_SHIFT = 8;

  // ==========================================================================
  // Source bit positions, lowest index wins
  // ==========================================================================
  localparam int SRC_EXT0 = 0;
  localparam int SRC_SP0_TX = 4;
  localparam int SRC_SP0_RX = 5;
  localparam int SRC_SP1_TX = 6;
  localparam int SRC_SP1_RX = 7;
  localparam int SRC_TIM0 = 8;
  localparam int SRC_TIM1 = 9;
  localparam int SRC_DMA0 = 10;
  localparam int SRC_DMA1 = 11;
  localparam int SRC_TRAP = 12;

  localparam logic [SRC_W-1:0] FLAG_RST = 13'h0000;

  typedef enum logic [1:0]
  {
    MAP_LOW = 2'h0,
    MAP_HIGH = 2'h1,
    MAP_RELOC = 2'h2
  } map_type;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_BOOT = 3'h4
  } state_type;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [3:0] src;
    logic is_branch;
  } vector_type;

endpackage

// File: hw/vec_addr_gen.sv
/*
  Interrupt vector address generator: latches requests, picks the winner
  by table position and presents the vector address to the sequencer.
  Assumes the sequencer acknowledges each vector with one pulse.
*/
`timescale 1ns/1ps
module vec_addr_gen #(
  parameter bit HAS_SPORT1 = 1'b1
)(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] EXT_IRQ_PINS,
  input wire logic SPORT0_TX_IRQ,
  input wire logic SPORT0_RX_IRQ,
  input wire logic SPORT1_TX_IRQ,
  input wire logic SPORT1_RX_IRQ,
  input wire logic TIMER0_IRQ,
  input wire logic TIMER1_IRQ,
  input wire logic DMA_CH0_IRQ,
  input wire logic DMA_CH1_IRQ,
  input wire logic TRAP_REQ,
  input wire logic [4:0] TRAP_NUM,
  input wire logic [1:0] MAP_MODE,
  input wire logic BOOT_LOADER,
  input wire logic [15:0] VECTOR_TABLE_PTR,
  input wire logic VEC_ACK,
  output logic [23:0] VEC_ADDR,
  output logic VEC_VALID,
  output logic VEC_IS_BRANCH,
  output logic [12:0] PENDING
);

  // ==========================================================================
  // Pin synchronisers, three stages, change accepted when last two agree
  // ==========================================================================
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ok_ff;
  logic [3:0] nxt_pin_ok;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      nxt_pin_ok[i] = (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i]
                                                     : pin_ok_ff[i];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pin_s1_ff <= 4'hF;
      pin_s2_ff <= 4'hF;
      pin_s3_ff <= 4'hF;
      pin_ok_ff <= 4'hF;
    end
    else
    begin
      pin_s1_ff <= EXT_IRQ_PINS;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ok_ff <= nxt_pin_ok;
    end
  end

  // ==========================================================================
  // Mode capture and flag register
  // ==========================================================================
  vec_addr_pkg::map_type map_ff, nxt_map;
  logic boot_ff, nxt_boot;
  logic rst_seen_ff, nxt_rst_seen;
  logic [12:0] flag_ff, nxt_flag;
  logic [4:0] trap_ff, nxt_trap;
  logic [3:0] pin_fall;
  logic [12:0] raw_req;

  // Pins are active low; a falling edge requests service
  assign pin_fall = pin_ok_ff & ~nxt_pin_ok;

  always_comb
  begin
    raw_req = vec_addr_pkg::FLAG_RST;
    raw_req[3:0] = pin_fall;
    raw_req[vec_addr_pkg::SRC_SP0_TX] = SPORT0_TX_IRQ;
    raw_req[vec_addr_pkg::SRC_SP0_RX] = SPORT0_RX_IRQ;
    // Serial port 1 slots are reserved on reduced and relocatable maps
    raw_req[vec_addr_pkg::SRC_SP1_TX] = SPORT1_TX_IRQ && HAS_SPORT1
      && (map_ff != vec_addr_pkg::MAP_RELOC);
    raw_req[vec_addr_pkg::SRC_SP1_RX] = SPORT1_RX_IRQ && HAS_SPORT1
      && (map_ff != vec_addr_pkg::MAP_RELOC);
    raw_req[vec_addr_pkg::SRC_TIM0] = TIMER0_IRQ;
    raw_req[vec_addr_pkg::SRC_TIM1] = TIMER1_IRQ;
    raw_req[vec_addr_pkg::SRC_DMA0] = DMA_CH0_IRQ;
    // Second DMA channel exists only in the relocatable map
    raw_req[vec_addr_pkg::SRC_DMA1] = DMA_CH1_IRQ
      && (map_ff == vec_addr_pkg::MAP_RELOC);
    // Traps 28..31 are reserved and ignored
    raw_req[vec_addr_pkg::SRC_TRAP] = TRAP_REQ
      && (TRAP_NUM <= vec_addr_pkg::TRAP_LAST);
  end

  // ==========================================================================
  // Priority select
  // ==========================================================================
  function automatic logic [3:0] pick(input logic [12:0] req);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = 12; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] offset_of(input logic [3:0] src,
                                           input logic [4:0] trap);
    logic [7:0] ofs;
    ofs = 8'h00;
    if (src == 4'(vec_addr_pkg::SRC_TRAP))
    begin
      ofs = vec_addr_pkg::OFS_TRAP0 + {3'h0, trap};
    end
    else
    begin
      // Sources sit at consecutive slots from 01h up to 0Ch
      ofs = vec_addr_pkg::OFS_EXT0 + {4'h0, src};
    end
    return ofs;
  endfunction

  vec_addr_pkg::state_type state_ff, nxt_state;
  vec_addr_pkg::vector_type vec_ff, nxt_vec;
  logic valid_ff, nxt_valid;
  logic [3:0] win;
  logic [7:0] win_ofs;
  logic [23:0] win_addr;

  assign win = pick(flag_ff);
  assign win_ofs = offset_of(win, trap_ff);

  always_comb
  begin
    case (map_ff)
      vec_addr_pkg::MAP_HIGH:
      begin
        win_addr = vec_addr_pkg::HIGH_BASE + {16'h0000, win_ofs};
      end
      vec_addr_pkg::MAP_RELOC:
      begin
        // Base low byte is zero, so the offset is simply appended
        win_addr = ({8'h00, VECTOR_TABLE_PTR} << vec_addr_pkg::BASE_SHIFT)
          + {16'h0000, win_ofs};
      end
      default:
      begin
        win_addr = {16'h0000, win_ofs};
      end
    endcase
  end

  always_comb
  begin
    nxt_map = map_ff;
    nxt_boot = boot_ff;
    nxt_rst_seen = 1'b1;
    nxt_flag = flag_ff;
    nxt_trap = trap_ff;
    nxt_state = state_ff;
    nxt_vec = vec_ff;
    nxt_valid = valid_ff;
    if (!rst_seen_ff)
    begin
      // Mode is static, captured once on the first edge after reset
      nxt_map = (MAP_MODE == 2'h1) ? vec_addr_pkg::MAP_HIGH
              : (MAP_MODE == 2'h2) ? vec_addr_pkg::MAP_RELOC
              : vec_addr_pkg::MAP_LOW;
      nxt_boot = BOOT_LOADER && (MAP_MODE == 2'h1);
    end
    case (state_ff)
      vec_addr_pkg::ST_BOOT:
      begin
        // Reset vector fetched at zero in every map
        nxt_vec.addr = 24'h000000;
        nxt_vec.src = 4'hF;
        nxt_vec.is_branch = 1'b0;
        nxt_valid = 1'b1;
        if (valid_ff && VEC_ACK)
        begin
          nxt_valid = 1'b0;
          nxt_state = vec_addr_pkg::ST_IDLE;
        end
      end
      vec_addr_pkg::ST_IDLE:
      begin
        if (flag_ff != vec_addr_pkg::FLAG_RST)
        begin
          nxt_vec.addr = win_addr;
          nxt_vec.src = win;
          // Boot-loader map words are executed branches
          nxt_vec.is_branch = boot_ff;
          nxt_valid = 1'b1;
          nxt_state = vec_addr_pkg::ST_BUSY;
        end
      end
      vec_addr_pkg::ST_BUSY:
      begin
        if (VEC_ACK)
        begin
          nxt_flag[vec_ff.src] = 1'b0;
          nxt_valid = 1'b0;
          nxt_state = vec_addr_pkg::ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = vec_addr_pkg::ST_IDLE;
        nxt_valid = 1'b0;
      end
    endcase
    // A new request wins over the clear in the same cycle
    nxt_flag = nxt_flag | raw_req;
    if (raw_req[vec_addr_pkg::SRC_TRAP] && !flag_ff[vec_addr_pkg::SRC_TRAP])
    begin
      nxt_trap = TRAP_NUM;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      map_ff <= vec_addr_pkg::MAP_LOW;
      boot_ff <= 1'b0;
      rst_seen_ff <= 1'b0;
      flag_ff <= vec_addr_pkg::FLAG_RST;
      trap_ff <= 5'h00;
      state_ff <= vec_addr_pkg::ST_BOOT;
      vec_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      map_ff <= nxt_map;
      boot_ff <= nxt_boot;
      rst_seen_ff <= nxt_rst_seen;
      flag_ff <= nxt_flag;
      trap_ff <= nxt_trap;
      state_ff <= nxt_state;
      vec_ff <= nxt_vec;
      valid_ff <= nxt_valid;
    end
  end

  assign VEC_ADDR = vec_ff.addr;
  assign VEC_VALID = valid_ff;
  assign VEC_IS_BRANCH = vec_ff.is_branch;
  assign PENDING = flag_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_valid_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY && !VEC_ACK) |=> VEC_VALID)
    else $error("valid dropped before acknowledge");
  a_ack_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY && VEC_ACK
     && !raw_req[vec_ff.src]) |=> !flag_ff[$past(vec_ff.src)])
    else $error("acknowledge did not clear flag");
  a_reset_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BOOT && VEC_VALID)
    |-> VEC_ADDR == 24'h000000)
    else $error("reset vector not at zero");
  a_low_range: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY && map_ff == vec_addr_pkg::MAP_LOW)
    |-> VEC_ADDR >= 24'h000001 && VEC_ADDR <= 24'h00003B)
    else $error("low map vector out of range");
  a_high_range: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY && map_ff == vec_addr_pkg::MAP_HIGH)
    |-> VEC_ADDR >= 24'h809FC1 && VEC_ADDR <= 24'h809FFB)
    else $error("high map vector out of range");
  a_reloc_base: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY && map_ff == vec_addr_pkg::MAP_RELOC)
    |-> VEC_ADDR[23:8] == VECTOR_TABLE_PTR)
    else $error("relocated base wrong");
  // Any move of an unacknowledged vector would let the core fetch twice
  a_one_at_time: assert property (@(posedge SYS_CLK) disable iff (RST)
    (VEC_VALID && !VEC_ACK) |=> VEC_VALID && $stable(VEC_ADDR))
    else $error("vector changed while outstanding");
  a_winner_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_IDLE && flag_ff[0])
    |=> VEC_ADDR[5:0] == 6'h01)
    else $error("priority order broken");
  a_branch_boot: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_ff == vec_addr_pkg::ST_BUSY) |-> VEC_IS_BRANCH == boot_ff)
    else $error("branch flag wrong");

  c_boot: cover property (@(posedge SYS_CLK) disable iff (RST)
    state_ff == vec_addr_pkg::ST_BOOT && VEC_ACK);
  c_two_pend: cover property (@(posedge SYS_CLK) disable iff (RST)
    $countones(flag_ff) > 1 && state_ff == vec_addr_pkg::ST_IDLE);
  c_trap: cover property (@(posedge SYS_CLK) disable iff (RST)
    VEC_VALID && vec_ff.src == 4'(vec_addr_pkg::SRC_TRAP));

endmodule // vec_addr_gen

// File: test/vec_seq_model.sv
/*
  Behavioural core sequencer that fetches vectors by acknowledging them.
  Assumes the generator holds each vector until it sees the acknowledge.
*/
`timescale 1ns/1ps
module vec_seq_model (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic VEC_VALID,
  output logic VEC_ACK
);
  int wait_cnt;

  // ==========================================================================
  // Acknowledge
  // ==========================================================================
  initial
  begin
    VEC_ACK = 1'b0;
    wait_cnt = 0;
  end

  // Random latency covers both prompt and slow fetches
  always @(posedge SYS_CLK)
  begin
    if (RST || VEC_ACK)
    begin
      VEC_ACK <= 1'b0;
      wait_cnt <= $urandom_range(3, 0);
    end
    else if (VEC_VALID === 1'b1)
    begin
      if (wait_cnt == 0)
        VEC_ACK <= 1'b1;
      else
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule // vec_seq_model

// File: test/tb.sv
/*
  Self-checking bench for the vector address generator, all three maps.
  Assumes the sequencer model acknowledges each presented vector.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed
  {
    logic [23:0] addr;
    logic br;
    logic chk;
  } exp_type;

  logic sys_clk, rst, vec_ack, vec_valid, vec_br, boot, boot_s;
  logic [12:0] irq_v, pending, red_pend;
  logic red_valid;
  logic [4:0] trap_num;
  logic [1:0] map_mode;
  logic [15:0] ptr;
  logic [23:0] vec_addr;
  vec_addr_pkg::map_type mode;
  exp_type exp_q[$];
  int err_total = 0;
  int tests_run = 0;
  int tn;

  // ==========================================================================
  // Clock, design and sequencer
  // ==========================================================================
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  vec_addr_gen u_dut (.SYS_CLK(sys_clk), .RST(rst),
    .EXT_IRQ_PINS(~irq_v[3:0]), .SPORT0_TX_IRQ(irq_v[4]),
    .SPORT0_RX_IRQ(irq_v[5]), .SPORT1_TX_IRQ(irq_v[6]),
    .SPORT1_RX_IRQ(irq_v[7]), .TIMER0_IRQ(irq_v[8]),
    .TIMER1_IRQ(irq_v[9]), .DMA_CH0_IRQ(irq_v[10]),
    .DMA_CH1_IRQ(irq_v[11]), .TRAP_REQ(irq_v[12]), .TRAP_NUM(trap_num),
    .MAP_MODE(map_mode), .BOOT_LOADER(boot), .VECTOR_TABLE_PTR(ptr),
    .VEC_ACK(vec_ack), .VEC_ADDR(vec_addr), .VEC_VALID(vec_valid),
    .VEC_IS_BRANCH(vec_br), .PENDING(pending));

  vec_seq_model u_seq (.SYS_CLK(sys_clk), .RST(rst),
    .VEC_VALID(vec_valid), .VEC_ACK(vec_ack));

  // Reduced variant, acknowledging itself: serial port 1 stays reserved
  vec_addr_gen #(.HAS_SPORT1(1'b0)) u_dut_red (.SYS_CLK(sys_clk),
    .RST(rst), .EXT_IRQ_PINS(~irq_v[3:0]), .SPORT0_TX_IRQ(irq_v[4]),
    .SPORT0_RX_IRQ(irq_v[5]), .SPORT1_TX_IRQ(irq_v[6]),
    .SPORT1_RX_IRQ(irq_v[7]), .TIMER0_IRQ(irq_v[8]),
    .TIMER1_IRQ(irq_v[9]), .DMA_CH0_IRQ(irq_v[10]),
    .DMA_CH1_IRQ(irq_v[11]), .TRAP_REQ(irq_v[12]), .TRAP_NUM(trap_num),
    .MAP_MODE(map_mode), .BOOT_LOADER(boot), .VECTOR_TABLE_PTR(ptr),
    .VEC_ACK(red_valid), .VEC_ADDR(), .VEC_VALID(red_valid),
    .VEC_IS_BRANCH(), .PENDING(red_pend));

  // ==========================================================================
  // Checks and helpers
  // ==========================================================================
  task automatic check_vec(exp_type e);
    tests_run++;
    if (vec_addr !== e.addr || (e.chk && vec_br !== e.br))
    begin
      err_total++;
      $display("Error vector: expected %h/%b seen %h/%b", e.addr, e.br,
        vec_addr, vec_br);
    end
  endtask

  task automatic check_pend(logic [12:0] exp);
    tests_run++;
    if (pending !== exp)
    begin
      err_total++;
      $display("Error pending: expected %h seen %h", exp, pending);
    end
  endtask

  function automatic logic [23:0] vaddr(logic [7:0] ofs);
    if (mode == vec_addr_pkg::MAP_HIGH)
      return vec_addr_pkg::HIGH_BASE + 24'(ofs);
    if (mode == vec_addr_pkg::MAP_RELOC)
      return {ptr, 8'h00} + 24'(ofs);
    return 24'(ofs);
  endfunction

  task automatic expect_src(logic [7:0] ofs);
    exp_type e;
    e.addr = vaddr(ofs);
    e.br = (mode == vec_addr_pkg::MAP_HIGH) && boot_s;
    e.chk = 1'b1;
    exp_q.push_back(e);
  endtask

  task automatic fire(logic [12:0] m, int hold);
    @(posedge sys_clk);
    irq_v <= m;
    repeat (hold) @(posedge sys_clk);
    irq_v <= '0;
  endtask

  // Bounded wait: a lost vector shows up as a leftover note
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (3) @(posedge sys_clk);
    if (exp_q.size() != 0)
    begin
      err_total++;
      $display("Error queue: expected 0 seen %0d", exp_q.size());
      exp_q.delete();
    end
    check_pend('0);
  endtask

  task automatic refuse(logic [12:0] m);
    fire(m, 1);
    repeat (4) @(posedge sys_clk);
    check_pend('0);
  endtask

  task automatic check_red();
    tests_run++;
    if (red_pend[7:6] !== 2'b00)
    begin
      err_total++;
      $display("Error reduced pending: expected 00 seen %b", red_pend[7:6]);
    end
  endtask

  task automatic test_done();
    $display("Checks run %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: every taken vector consumes the oldest note
  // ==========================================================================
  always @(posedge sys_clk)
  begin
    if (rst === 1'b0 && vec_valid === 1'b1 && vec_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_total++;
        $display("Error vector: expected none seen %h", vec_addr);
      end
      else
        check_vec(exp_q.pop_front());
    end
  end

  // A wrongly latched slot stands at least two edges before self-ack
  always @(posedge sys_clk)
  begin
    if (rst === 1'b0)
      check_red();
  end

  initial
  begin
    #(100 * 20000);
    err_total++;
    $display("Error watchdog: expected done seen hang");
    test_done();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    exp_type r;
    irq_v = '0;
    trap_num = '0;
    map_mode = '0;
    boot = 1'b0;
    boot_s = 1'b0;
    ptr = '0;
    rst = 1'b1;
    r = '0;
    void'($urandom(43));
    for (int mi = 0; mi < 3; mi++)
    begin
      mode = vec_addr_pkg::map_type'(mi);
      boot_s = (mi == 1);
      @(posedge sys_clk);
      rst <= 1'b1;
      map_mode <= mode;
      boot <= boot_s;
      ptr <= 16'($urandom);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      exp_q.push_back(r);
      @(posedge sys_clk);
      // Mode inputs move after sampling; the map must not follow
      map_mode <= (mi == 0) ? 2'h2 : 2'h0;
      boot <= ~boot_s;
      drain();
      for (int s = 0; s < 12; s++)
      begin
        if ((mi == 2 && (s == 6 || s == 7)) || (mi != 2 && s == 11))
          refuse(13'(1 << s));
        else
        begin
          expect_src(vec_addr_pkg::OFS_EXT0 + 8'(s));
          fire(13'(1 << s), (s < 4) ? 6 : 1);
          drain();
        end
      end
      for (int k = 0; k < 4; k++)
      begin
        tn = (k == 0) ? 0 : (k == 1) ? 27 : (k == 2) ?
          $urandom_range(26, 1) : $urandom_range(31, 28);
        trap_num <= 5'(tn);
        if (k == 3)
          refuse(13'h1000);
        else
        begin
          expect_src(vec_addr_pkg::OFS_TRAP0 + 8'(tn));
          fire(13'h1000, 1);
          drain();
        end
      end
      expect_src(vec_addr_pkg::OFS_SP0_RX);
      expect_src(vec_addr_pkg::OFS_TIM0);
      expect_src(vec_addr_pkg::OFS_DMA0);
      fire(13'h0520, 1);
      drain();
    end
    test_done();
  end
endmodule // tb
